// ===== rtl/tsp_pkg.sv
// constants, types and helpers of the backplane stream port
package tsp_pkg;

   // ********************************************************
   // frame layout
   // ********************************************************
   localparam int          SLOTS         = 32;
   localparam int          SLOT_W        = 5;
   localparam int          BIT_W         = 3;
   localparam int          T1_CHANNELS   = 24;
   localparam int          E1_CHANNELS   = 30;
   localparam int          SIG_NIBBLES   = 30;
   localparam int          STREAM_KBPS   = 2048;
   localparam logic [2:0]  LAST_BIT      = 3'h7;
   localparam logic [4:0]  FIRST_SLOT    = 5'h00;
   localparam logic [4:0]  E1_ALIGN_SLOT = 5'h00;
   localparam logic [4:0]  E1_SIG_SLOT   = 5'h10;
   localparam logic [4:0]  T1_FIRST_SLOT = 5'h01;
   localparam logic [4:0]  T1_LAST_SLOT  = 5'h18;

   // ********************************************************
   // idle fill and nibble placement
   // ********************************************************
   localparam logic [7:0]  IDLE_BYTE     = 8'hff;
   localparam logic [3:0]  NIB_FILL      = 4'hf;
   localparam logic [3:0]  NIB_NONE      = 4'h0;
   localparam logic [7:0]  OE_UPPER      = 8'hf0;
   localparam logic [7:0]  OE_LOWER      = 8'h0f;
   localparam logic [7:0]  OE_NONE       = 8'h00;
   localparam logic [2:0]  NIB_SPLIT     = 3'h4;

   // ********************************************************
   // configuration vector bit positions
   // ********************************************************
   localparam int          CFG_W         = 3;
   localparam int          CFG_UPPER     = 0;
   localparam int          CFG_REG_SIG   = 1;
   localparam int          CFG_E1        = 2;

   // ********************************************************
   // timing
   // ********************************************************
   localparam int          CLK_MHZ       = 250;
   localparam int          RESET_MIN_NS  = 1000;
   localparam int          RESET_MIN_CYC =
      (RESET_MIN_NS * CLK_MHZ + 999) / 1000;

   // ********************************************************
   // link state
   // ********************************************************
   typedef enum logic [1:0] {
      LINK_HUNT = 2'b01,
      LINK_RUN  = 2'b10
   } tsp_link_e;

   // slot carries a channel in the chosen mode
   function automatic logic tsp_slot_active(input logic [4:0] s,
                                            input logic       e1);
      logic r;
      r = 1'b0;
      if (e1) begin
         r = (s != E1_ALIGN_SLOT) && (s != E1_SIG_SLOT);
      end else begin
         r = (s >= T1_FIRST_SLOT) && (s <= T1_LAST_SLOT);
      end
      return r;
   endfunction

endpackage

// ===== rtl/tsp_sync.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/100ps
module tsp_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             reset,
   // data
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] s1;
   logic [WIDTH-1:0] s2;
   logic [WIDTH-1:0] s3;

   initial begin
      if (WIDTH < 1) begin
         $error("tsp_sync width below one");
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end else begin
         s1 <= d;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // per bit: take the value once second and third agree
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               q[i] <= 1'b0;
            end else if (s2[i] == s3[i]) begin
               q[i] <= s3[i];
            end
         end
      end
   endgenerate

endmodule

// ===== rtl/tsp_stream_port.sv
// serial timeslot port: pcm and signaling streams to the backplane
`timescale 1ns/100ps

// What this block does
// - drive 24/30 receive signaling nibbles on status stream
// - upper select 1: nibble high, low half tristated
// - upper select 0: nibble low, high half tristated
// - take transmit signaling from control input stream
// - register-sourced signaling: control input fully ignored
// - control input uses nibble chosen by upper select
// - output received 24/30 channels on pcm stream
// - take 24/30 channels to send from pcm input
module tsp_stream_port (
   // core clock and reset
   input  wire logic                      clk,
   input  wire logic                      reset,
   // stream timing
   input  wire logic                      stream_clk,
   input  wire logic                      frame_start_n,
   // stream pins
   output logic                           pcm_data_out,
   input  wire logic                      pcm_data_in,
   output logic                           signaling_status_out,
   output logic                           signaling_status_oe,
   input  wire logic                      signaling_control_in,
   // configuration
   input  wire logic                      upper_nibble_select,
   input  wire logic                      register_sourced_signaling,
   input  wire logic                      e1_mode,
   // receive channels from the framer
   input  wire logic                      rx_write,
   input  wire logic [tsp_pkg::SLOT_W-1:0] rx_slot,
   input  wire logic [7:0]                rx_byte,
   input  wire logic [3:0]                rx_sig,
   output logic                           rx_ready,
   // transmit channels to the framer
   output logic                           tx_valid,
   output logic [tsp_pkg::SLOT_W-1:0]     tx_slot,
   output logic [7:0]                     tx_byte,
   output logic [3:0]                     tx_sig
);

   localparam int SW = tsp_pkg::SLOT_W;

   // ********************************************************
   // core side: receive write handshake
   // ********************************************************
   logic          rx_req;
   logic          rx_ack_q;
   logic [SW-1:0] rx_hold_slot;
   logic [7:0]    rx_hold_byte;
   logic [3:0]    rx_hold_sig;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rx_req       <= 1'b0;
         rx_hold_slot <= '0;
         rx_hold_byte <= tsp_pkg::IDLE_BYTE;
         rx_hold_sig  <= tsp_pkg::NIB_FILL;
      end else if (rx_write && rx_ready) begin
         rx_req       <= ~rx_req;
         rx_hold_slot <= rx_slot;
         rx_hold_byte <= rx_byte;
         rx_hold_sig  <= rx_sig;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rx_ready <= 1'b1;
      end else if (rx_write && rx_ready) begin
         rx_ready <= 1'b0;
      end else if (rx_ack_q == rx_req) begin
         rx_ready <= 1'b1;
      end
   end

   // ********************************************************
   // core side: transmit channel delivery
   // ********************************************************
   logic          tx_req_q;
   logic          tx_seen;
   logic          tx_req;
   logic [SW-1:0] tx_hold_slot;
   logic [7:0]    tx_hold_byte;
   logic [3:0]    tx_hold_sig;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tx_seen  <= 1'b0;
         tx_valid <= 1'b0;
         tx_slot  <= '0;
         tx_byte  <= '0;
         tx_sig   <= '0;
      end else if (tx_req_q != tx_seen) begin
         tx_seen  <= tx_req_q;
         tx_valid <= 1'b1;
         tx_slot  <= tx_hold_slot;
         tx_byte  <= tx_hold_byte;
         tx_sig   <= tx_hold_sig;
      end else begin
         tx_valid <= 1'b0;
      end
   end

   // ********************************************************
   // link side reset and crossings
   // ********************************************************
   logic                      link_rst_meta;
   logic                      link_rst;
   logic [tsp_pkg::CFG_W-1:0] cfg_l;
   logic                      rx_req_l;
   logic                      rx_seen;

   always_ff @(posedge stream_clk or posedge reset) begin
      if (reset) begin
         link_rst_meta <= 1'b1;
         link_rst      <= 1'b1;
      end else begin
         link_rst_meta <= 1'b0;
         link_rst      <= link_rst_meta;
      end
   end

   tsp_sync #(.WIDTH(tsp_pkg::CFG_W)) u_cfg_sync (
      .clk   (stream_clk),
      .reset (link_rst),
      .d     ({e1_mode, register_sourced_signaling,
               upper_nibble_select}),
      .q     (cfg_l)
   );

   tsp_sync #(.WIDTH(1)) u_rx_req_sync (
      .clk   (stream_clk),
      .reset (link_rst),
      .d     (rx_req),
      .q     (rx_req_l)
   );

   tsp_sync #(.WIDTH(1)) u_rx_ack_sync (
      .clk   (clk),
      .reset (reset),
      .d     (rx_seen),
      .q     (rx_ack_q)
   );

   tsp_sync #(.WIDTH(1)) u_tx_req_sync (
      .clk   (clk),
      .reset (reset),
      .d     (tx_req),
      .q     (tx_req_q)
   );

   wire upper_l = cfg_l[tsp_pkg::CFG_UPPER];
   wire reg_l   = cfg_l[tsp_pkg::CFG_REG_SIG];
   wire e1_l    = cfg_l[tsp_pkg::CFG_E1];

   // ********************************************************
   // link side: channel tables
   // ********************************************************
   logic [7:0] rx_data_mem [tsp_pkg::SLOTS];
   logic [3:0] rx_sig_mem  [tsp_pkg::SLOTS];

   always_ff @(posedge stream_clk or posedge link_rst) begin
      if (link_rst) begin
         rx_seen <= 1'b0;
         for (int i = 0; i < tsp_pkg::SLOTS; i++) begin
            rx_data_mem[i] <= tsp_pkg::IDLE_BYTE;
            rx_sig_mem[i]  <= tsp_pkg::NIB_FILL;
         end
      end else if (rx_req_l != rx_seen) begin
         rx_seen                   <= rx_req_l;
         rx_data_mem[rx_hold_slot] <= rx_hold_byte;
         rx_sig_mem[rx_hold_slot]  <= rx_hold_sig;
      end
   end

   // ********************************************************
   // link side: frame timing
   // ********************************************************
   tsp_pkg::tsp_link_e        link_state;
   logic [tsp_pkg::BIT_W-1:0] bit_cnt;
   logic [SW-1:0]             slot;
   logic [SW-1:0]             next_slot;
   logic                      load_slot;
   logic                      run;

   assign run       = (link_state == tsp_pkg::LINK_RUN);
   assign load_slot = !frame_start_n ||
                      (run && bit_cnt == tsp_pkg::LAST_BIT);
   assign next_slot = !frame_start_n ? tsp_pkg::FIRST_SLOT
                                     : SW'(slot + 1'b1);

   always_ff @(posedge stream_clk or posedge link_rst) begin
      if (link_rst) begin
         link_state <= tsp_pkg::LINK_HUNT;
      end else begin
         case (link_state)
            tsp_pkg::LINK_HUNT: begin
               if (!frame_start_n) begin
                  link_state <= tsp_pkg::LINK_RUN;
               end
            end
            tsp_pkg::LINK_RUN: begin
               link_state <= tsp_pkg::LINK_RUN;
            end
            default: begin
               link_state <= tsp_pkg::LINK_HUNT;
            end
         endcase
      end
   end

   always_ff @(posedge stream_clk or posedge link_rst) begin
      if (link_rst) begin
         bit_cnt <= '0;
         slot    <= '0;
      end else if (!frame_start_n) begin
         bit_cnt <= '0;
         slot    <= tsp_pkg::FIRST_SLOT;
      end else if (run) begin
         bit_cnt <= bit_cnt + 1'b1;
         if (bit_cnt == tsp_pkg::LAST_BIT) begin
            slot <= next_slot;
         end
      end
   end

   // ********************************************************
   // link side: output streams
   // ********************************************************
   logic [7:0] data_shift;
   logic [7:0] sig_shift;
   logic [7:0] oe_shift;
   logic       slot_active_q;
   logic       nib_upper_q;
   logic       next_active;
   logic [3:0] next_nib;

   assign next_active = tsp_pkg::tsp_slot_active(next_slot, e1_l);
   assign next_nib    = rx_sig_mem[next_slot];

   always_ff @(posedge stream_clk or posedge link_rst) begin
      if (link_rst) begin
         data_shift    <= tsp_pkg::IDLE_BYTE;
         sig_shift     <= tsp_pkg::IDLE_BYTE;
         oe_shift      <= tsp_pkg::OE_NONE;
         slot_active_q <= 1'b0;
         nib_upper_q   <= 1'b1;
      end else if (load_slot) begin
         slot_active_q <= next_active;
         nib_upper_q   <= upper_l;
         if (next_active) begin
            data_shift <= rx_data_mem[next_slot];
         end else begin
            data_shift <= tsp_pkg::IDLE_BYTE;
         end
         if (next_active && upper_l) begin
            sig_shift <= {next_nib, tsp_pkg::NIB_FILL};
            oe_shift  <= tsp_pkg::OE_UPPER;
         end else if (next_active) begin
            sig_shift <= {tsp_pkg::NIB_FILL, next_nib};
            oe_shift  <= tsp_pkg::OE_LOWER;
         end else begin
            sig_shift <= tsp_pkg::IDLE_BYTE;
            oe_shift  <= tsp_pkg::OE_NONE;
         end
      end else if (run) begin
         data_shift <= {data_shift[6:0], 1'b1};
         sig_shift  <= {sig_shift[6:0], 1'b1};
         oe_shift   <= {oe_shift[6:0], 1'b0};
      end
   end

   assign pcm_data_out         = data_shift[7];
   assign signaling_status_out = sig_shift[7];
   assign signaling_status_oe  = oe_shift[7];

   // ********************************************************
   // link side: input streams
   // ********************************************************
   logic [6:0] data_in_shift;
   logic [6:0] sig_in_shift;
   logic [7:0] data_in_byte;
   logic [7:0] sig_in_byte;
   logic       capture;

   assign data_in_byte = {data_in_shift, pcm_data_in};
   assign sig_in_byte  = {sig_in_shift, signaling_control_in};
   assign capture      = run && bit_cnt == tsp_pkg::LAST_BIT &&
                         tsp_pkg::tsp_slot_active(slot, e1_l);

   always_ff @(posedge stream_clk or posedge link_rst) begin
      if (link_rst) begin
         data_in_shift <= '0;
         sig_in_shift  <= '0;
      end else if (run) begin
         data_in_shift <= data_in_byte[6:0];
         sig_in_shift  <= sig_in_byte[6:0];
      end
   end

   always_ff @(posedge stream_clk or posedge link_rst) begin
      if (link_rst) begin
         tx_req       <= 1'b0;
         tx_hold_slot <= '0;
         tx_hold_byte <= '0;
         tx_hold_sig  <= '0;
      end else if (capture) begin
         tx_req       <= ~tx_req;
         tx_hold_slot <= slot;
         tx_hold_byte <= data_in_byte;
         if (reg_l) begin
            tx_hold_sig <= tsp_pkg::NIB_NONE;
         end else if (upper_l) begin
            tx_hold_sig <= sig_in_byte[7:4];
         end else begin
            tx_hold_sig <= sig_in_byte[3:0];
         end
      end
   end

   // ********************************************************
   // checks
   // ********************************************************
   a_frame_align: assert property (
      @(posedge stream_clk) disable iff (link_rst)
      !frame_start_n |=> bit_cnt == '0 && slot == '0)
      else $error("frame pulse did not align counters");

   a_slot_wrap: assert property (
      @(posedge stream_clk) disable iff (link_rst)
      run && frame_start_n && bit_cnt == tsp_pkg::LAST_BIT |=>
      bit_cnt == '0 && slot == SW'($past(slot) + 1'b1))
      else $error("slot did not advance after eighth bit");

   a_oe_upper: assert property (
      @(posedge stream_clk) disable iff (link_rst)
      run && slot_active_q && nib_upper_q |->
      signaling_status_oe == (bit_cnt < tsp_pkg::NIB_SPLIT))
      else $error("upper nibble drive window wrong");

   a_oe_lower: assert property (
      @(posedge stream_clk) disable iff (link_rst)
      run && slot_active_q && !nib_upper_q |->
      signaling_status_oe == (bit_cnt >= tsp_pkg::NIB_SPLIT))
      else $error("lower nibble drive window wrong");

   a_idle_slot: assert property (
      @(posedge stream_clk) disable iff (link_rst)
      !slot_active_q |-> pcm_data_out && !signaling_status_oe)
      else $error("idle slot not idle");

   a_reg_ignore: assert property (
      @(posedge stream_clk) disable iff (link_rst)
      capture && reg_l |=> tx_hold_sig == tsp_pkg::NIB_NONE)
      else $error("control input used while register sourced");

   a_sig_take: assert property (
      @(posedge stream_clk) disable iff (link_rst)
      capture && !reg_l |=> tx_hold_sig == ($past(upper_l) ?
      $past(sig_in_byte[7:4]) : $past(sig_in_byte[3:0])))
      else $error("wrong control nibble taken");

   a_data_take: assert property (
      @(posedge stream_clk) disable iff (link_rst)
      capture |=> tx_hold_byte == $past(data_in_byte) && tx_req != $past(tx_req))
      else $error("transmit byte not captured");

   a_tx_pulse: assert property (
      @(posedge clk) disable iff (reset)
      tx_valid |=> !tx_valid)
      else $error("transmit valid longer than one cycle");

   a_rx_return: assert property (
      @(posedge clk) disable iff (reset)
      rx_write && rx_ready |=> !rx_ready ##[1:40] rx_ready)
      else $error("receive handshake did not complete");

   c_frame: cover property (
      @(posedge stream_clk) disable iff (link_rst)
      run && !frame_start_n);

   c_rx_write: cover property (
      @(posedge clk) disable iff (reset)
      rx_write && rx_ready);

   c_tx_sig: cover property (
      @(posedge clk) disable iff (reset)
      tx_valid && tx_sig != '0);

   c_lower: cover property (
      @(posedge stream_clk) disable iff (link_rst)
      slot_active_q && !nib_upper_q && signaling_status_oe);

endmodule

// ===== tb/tsp_switch_model.sv
// far-side timeslot switch model: frame timing, input streams, capture
`timescale 1ns/100ps
module tsp_switch_model (
   // link clock and data pattern
   input  wire logic       stream_clk,
   input  wire logic [7:0] pattern,
   // stream pins
   output logic            frame_start_n,
   output logic            pcm_data_in,
   output logic            signaling_control_in,
   input  wire logic       pcm_data_out,
   input  wire logic       sig_wire,
   input  wire logic       signaling_status_oe
);
   // ********************************************************
   // frame position and captured slots
   // ********************************************************
   logic [7:0] cnt;
   logic [7:0] pos;
   logic [7:0] cap_pcm [32];
   logic [7:0] cap_sig [32];
   logic [7:0] cap_oe  [32];

   // bit of a slot byte at frame position p, msb first
   function automatic logic pick(input logic [7:0] b, input logic [7:0] p);
      return b[3'h7 - p[2:0]];
   endfunction

   initial begin
      cnt                  = 8'h00;
      frame_start_n        = 1'b1;
      pcm_data_in          = 1'b1;
      signaling_control_in = 1'b1;
   end

   // ********************************************************
   // drive frame pulse and input streams
   // ********************************************************
   always @(posedge stream_clk) begin
      cnt           <= cnt + 8'h01;
      frame_start_n <= (cnt != 8'hff);
      pcm_data_in   <= pick(pattern + {3'h0, cnt[7:3]}, cnt);
      signaling_control_in <= pick({cnt[6:3] ^ 4'h5, cnt[6:3] ^ 4'ha},
                                   cnt);
   end

   // ********************************************************
   // capture output streams mid-bit
   // ********************************************************
   always @(negedge stream_clk) begin
      pos = cnt - 8'h01;
      cap_pcm[pos[7:3]][3'h7 - pos[2:0]] <= pcm_data_out;
      cap_sig[pos[7:3]][3'h7 - pos[2:0]] <= sig_wire;
      cap_oe[pos[7:3]][3'h7 - pos[2:0]]  <= signaling_status_oe;
   end
endmodule

// ===== tb/tsp_stream_port_tb.sv
// self-checking bench of the backplane stream port
`timescale 1ns/100ps
module tsp_stream_port_tb;
   localparam int         LIMIT = 30000;
   localparam logic [7:0] PAT   = 8'h3c;
   logic                  clk;
   logic                  reset;
   logic                  stream_clk;
   logic                  frame_start_n;
   logic                  pcm_data_out;
   logic                  pcm_data_in;
   logic                  signaling_status_out;
   logic                  signaling_status_oe;
   logic                  signaling_control_in;
   logic                  sig_wire;
   logic                  upper_nibble_select;
   logic                  register_sourced_signaling;
   logic                  e1_mode;
   logic                  rx_write;
   logic [4:0]            rx_slot;
   logic [7:0]            rx_byte;
   logic [3:0]            rx_sig;
   logic                  rx_ready;
   logic                  tx_valid;
   logic [4:0]            tx_slot;
   logic [7:0]            tx_byte;
   logic [3:0]            tx_sig;
   logic                  seen [32];
   logic [11:0]           txd  [32];
   int                    mismatches;
   int                    tests_run;
   int                    cycles = 0;

   assign sig_wire = signaling_status_oe ? signaling_status_out : 1'bz;

   tsp_stream_port DUT (
      .clk(clk), .reset(reset), .stream_clk(stream_clk),
      .frame_start_n(frame_start_n), .pcm_data_out(pcm_data_out),
      .pcm_data_in(pcm_data_in), .signaling_status_out(signaling_status_out),
      .signaling_status_oe(signaling_status_oe),
      .signaling_control_in(signaling_control_in),
      .upper_nibble_select(upper_nibble_select),
      .register_sourced_signaling(register_sourced_signaling),
      .e1_mode(e1_mode), .rx_write(rx_write), .rx_slot(rx_slot),
      .rx_byte(rx_byte), .rx_sig(rx_sig), .rx_ready(rx_ready),
      .tx_valid(tx_valid), .tx_slot(tx_slot), .tx_byte(tx_byte),
      .tx_sig(tx_sig)
   );

   tsp_switch_model PEER (
      .stream_clk(stream_clk), .pattern(PAT), .frame_start_n(frame_start_n),
      .pcm_data_in(pcm_data_in), .signaling_control_in(signaling_control_in),
      .pcm_data_out(pcm_data_out), .sig_wire(sig_wire),
      .signaling_status_oe(signaling_status_oe)
   );

   // ********************************************************
   // clocks, transmit monitor and hang limit
   // ********************************************************
   initial clk = 1'b0;
   always #2 clk = ~clk;
   initial stream_clk = 1'b0;
   always #7.5 stream_clk = ~stream_clk;

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (tx_valid === 1'b1) begin
         seen[tx_slot] <= 1'b1;
         txd[tx_slot]  <= {tx_sig, tx_byte};
      end
      if (cycles == LIMIT) begin
         mismatches++;
         tally_and_finish();
      end
   end

   // ********************************************************
   // shared tasks
   // ********************************************************
   task automatic check(input logic [11:0] got, input logic [11:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   function automatic logic active(input logic [4:0] s, input logic e1);
      return e1 ? (s != 5'h00 && s != 5'h10) : (s >= 5'h01 && s <= 5'h18);
   endfunction

   // one receive entry through the ready handshake
   task automatic write_slot(input logic [4:0] s);
      @(posedge clk);
      rx_write <= 1'b1;
      rx_slot  <= s;
      rx_byte  <= 8'h40 + {3'h0, s};
      rx_sig   <= ~s[3:0];
      @(posedge clk);
      while (rx_ready !== 1'b1) @(posedge clk);
      rx_write <= 1'b0;
   endtask

   // ********************************************************
   // scenario: one configuration, both stream directions
   // ********************************************************
   task automatic run_mode(input logic e1, input logic up, input logic rs);
      logic       a;
      logic [4:0] sl;
      logic [7:0] sb;
      logic [7:0] cs;
      @(posedge clk);
      e1_mode                    <= e1;
      upper_nibble_select        <= up;
      register_sourced_signaling <= rs;
      repeat (3000) @(posedge clk);
      @(negedge clk);
      for (int s = 0; s < 32; s++) seen[s] = 1'b0;
      repeat (1100) @(posedge clk);
      @(negedge clk);
      for (int s = 0; s < 32; s++) begin
         sl = s[4:0];
         a  = active(sl, e1);
         sb = {sl[3:0] ^ 4'h5, sl[3:0] ^ 4'ha};
         cs = PEER.cap_sig[s];
         check({4'h0, PEER.cap_pcm[s]},
               a ? {4'h0, 8'h40 + {3'h0, sl}} : 12'h0ff);
         check({4'h0, PEER.cap_oe[s]},
               a ? (up ? 12'h0f0 : 12'h00f) : 12'h000);
         if (a) begin
            check({8'h0, up ? cs[7:4] : cs[3:0]},
                  {8'h0, ~sl[3:0]});
            check(txd[s], {rs ? 4'h0 : (up ? sb[7:4] : sb[3:0]),
                           PAT + {3'h0, sl}});
         end
         check({11'h0, seen[s]}, {11'h0, a});
      end
   endtask

   // ********************************************************
   // main sequence
   // ********************************************************
   initial begin
      reset                      = 1'b1;
      rx_write                   = 1'b0;
      rx_slot                    = 5'h00;
      rx_byte                    = 8'h00;
      rx_sig                     = 4'h0;
      e1_mode                    = 1'b1;
      upper_nibble_select        = 1'b1;
      register_sourced_signaling = 1'b0;
      mismatches                 = 0;
      tests_run                  = 0;
      repeat (tsp_pkg::RESET_MIN_CYC) @(posedge clk);
      check({8'h0, pcm_data_out, signaling_status_oe, rx_ready, tx_valid},
            12'h00a);
      reset <= 1'b0;
      for (int s = 0; s < 32; s++) write_slot(s[4:0]);
      run_mode(1'b1, 1'b1, 1'b0);
      run_mode(1'b1, 1'b0, 1'b0);
      run_mode(1'b0, 1'b1, 1'b0);
      run_mode(1'b0, 1'b0, 1'b1);
      tally_and_finish();
   end
endmodule
